/* File: shared/dll_switch_pkg.sv */
// Constants, types and commands for the DLL on/off switch sequencer.
// Assumes the DRAM clock runs at the ref clock rate while counting.
package dll_switch_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PS = 25000;

  // Rounded up, never below the cycle floor
  function automatic int ns_to_cyc(input int ns, input int floor_nck);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c > floor_nck) ? c : floor_nck;
  endfunction

  localparam int MOD_NS     = 15;
  localparam int MOD_CYC    = ns_to_cyc(MOD_NS, 12);
  localparam int MRD_CYC    = 4;
  localparam int CKSRE_NS   = 10;
  localparam int CKSRE_CYC  = ns_to_cyc(CKSRE_NS, 5);
  localparam int CKSRX_NS   = 10;
  localparam int CKSRX_CYC  = ns_to_cyc(CKSRX_NS, 5);
  localparam int XS_NS      = 270;
  localparam int XS_CYC     = ns_to_cyc(XS_NS, 5);
  localparam int DLLK_CYC   = 512;
  localparam int ZQOPER_CYC = 512;
  localparam int CNT_W      = 10;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [4:0] CTRL_OFS   = 5'h00;
  localparam logic [4:0] STATUS_OFS = 5'h04;
  localparam logic [4:0] MR0_OFS    = 5'h08;
  localparam logic [4:0] MR1_OFS    = 5'h0C;
  localparam logic [4:0] MR2_OFS    = 5'h10;
  localparam int CTRL_GO    = 0;
  localparam int CTRL_TOOFF = 1;
  localparam int CTRL_ZQ    = 2;
  localparam int DLL_DIS_BIT = 0;
  localparam int DLL_RST_BIT = 8;
  localparam int ZQ_LONG_BIT = 10;
  localparam logic [13:0] MR_RST = 14'h0000;

  // ****************************************
  // Pin bundle and commands
  // ****************************************
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        odt;
    logic [2:0]  ba;
    logic [13:0] addr;
  } dram_cmd_t;

  localparam logic [3:0] OP_NOP = 4'h7;
  localparam logic [3:0] OP_MRS = 4'h0;
  localparam logic [3:0] OP_REF = 4'h1;
  localparam logic [3:0] OP_ZQ  = 4'h6;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DIS_DLL, ST_SRE, ST_CLK_REQ, ST_SRX, ST_EN_DLL,
    ST_RST_DLL, ST_MR2, ST_MR0, ST_ZQ, ST_FINISH, ST_WAIT
  } seq_state_t;

endpackage

/* File: src/dll_switch_ctrl.sv */
// Sequencer that moves a DRAM between DLL-on and DLL-off operation.
// Assumes an outside clock generator that changes the DRAM clock
// on request and reports when the new clock is stable.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps

module dll_switch_ctrl
  import dll_switch_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        clk_stable_in,
  output logic             clk_change_req_out,
  output dram_cmd_t        dram_out
);

  // ****************************************
  // State
  // ****************************************
  seq_state_t       state;
  seq_state_t       ret_state;
  logic [CNT_W-1:0] wait_cnt;
  logic [CNT_W-1:0] lock_cnt;
  logic [CNT_W-1:0] zq_cnt;
  logic             to_off;
  logic             zq_en;
  logic             dll_off;
  logic             done;
  logic             cke_level;
  logic             clk_req;
  logic [13:0]      mr0_val;
  logic [13:0]      mr1_val;
  logic [13:0]      mr2_val;
  logic             ack;
  dram_cmd_t        next_cmd;

  // ****************************************
  // Avalon slave decode
  // ****************************************
  wire req      = avs_read_in | avs_write_in;
  wire take     = req & ~ack;
  // Writes land at the edge that shows waitrequest low to the master
  wire wr_take  = avs_write_in & ack;
  wire sel_ctrl = avs_address_in == CTRL_OFS;
  wire sel_stat = avs_address_in == STATUS_OFS;
  wire sel_mr0  = avs_address_in == MR0_OFS;
  wire sel_mr1  = avs_address_in == MR1_OFS;
  wire sel_mr2  = avs_address_in == MR2_OFS;
  wire idle     = state == ST_IDLE;

  // Start only from idle; caller guarantees banks closed
  wire go = wr_take & sel_ctrl & idle &
            avs_writedata_in[CTRL_GO];

  // Mode values are frozen while a switch runs
  wire mr_wr = wr_take & idle;

  wire [31:0] ctrl_rd = {29'h0000_0000, zq_en, to_off, 1'b0};
  wire [31:0] stat_rd = {24'h00_0000, state, 1'b0, dll_off,
                         done, ~idle};

  wire [31:0] rd_mux =
    sel_ctrl ? ctrl_rd :
    sel_stat ? stat_rd :
    sel_mr0  ? {18'h0_0000, mr0_val} :
    sel_mr1  ? {18'h0_0000, mr1_val} :
    sel_mr2  ? {18'h0_0000, mr2_val} : 32'h0000_0000;

  // One wait cycle: data is registered, then released
  assign avs_waitrequest_out = req & ~ack;

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      ack              <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      ack <= take;
      if (take) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      to_off  <= 1'b0;
      zq_en   <= 1'b0;
      mr0_val <= MR_RST;
      mr1_val <= MR_RST;
      mr2_val <= MR_RST;
    end else begin
      if (mr_wr && sel_ctrl) begin
        to_off <= avs_writedata_in[CTRL_TOOFF];
        zq_en  <= avs_writedata_in[CTRL_ZQ];
      end
      if (mr_wr && sel_mr0) begin
        mr0_val <= avs_writedata_in[13:0];
      end
      if (mr_wr && sel_mr1) begin
        mr1_val <= avs_writedata_in[13:0];
      end
      if (mr_wr && sel_mr2) begin
        mr2_val <= avs_writedata_in[13:0];
      end
    end
  end

  // ****************************************
  // Command helpers
  // ****************************************
  // ODT is never raised by this block: it stays static low through
  // both switches, which is legal whether or not termination is on.
  function automatic dram_cmd_t mk_cmd(
    input logic        cke,
    input logic [3:0]  op,
    input logic [2:0]  ba,
    input logic [13:0] addr
  );
    dram_cmd_t c;
    c.cke   = cke;
    c.cs_n  = op[3];
    c.ras_n = op[2];
    c.cas_n = op[1];
    c.we_n  = op[0];
    c.odt   = 1'b0;
    c.ba    = ba;
    c.addr  = addr;
    return c;
  endfunction

  // Mode words with the DLL control bits forced
  wire [13:0] mr1_dis = mr1_val | 14'h0001;
  wire [13:0] mr1_en  = mr1_val & ~14'h0001;
  wire [13:0] mr0_rst = mr0_val | 14'h0100;
  wire [13:0] mr0_nrs = mr0_val & ~14'h0100;
  wire [13:0] zq_addr = 14'h0400;

  wire wait_done = wait_cnt == '0;

  function automatic logic [CNT_W-1:0] ld(input int n);
    return CNT_W'(n - 1);
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_t       next_state;
  seq_state_t       next_ret;
  logic [CNT_W-1:0] next_wait;
  logic             next_cke;
  logic             next_req;
  logic             lock_load;
  logic             zq_load;
  logic             set_off;
  logic             clr_off;
  logic             finish;

  always_comb begin
    next_state = state;
    next_ret   = ret_state;
    next_wait  = wait_cnt;
    next_cke   = cke_level;
    next_req   = clk_req;
    lock_load  = 1'b0;
    zq_load    = 1'b0;
    set_off    = 1'b0;
    clr_off    = 1'b0;
    finish     = 1'b0;
    // Default is a no-operation
    next_cmd   = mk_cmd(cke_level, OP_NOP, 3'h0, 14'h0000);
    unique case (state)
      ST_IDLE: begin
        if (go) begin
          next_state = avs_writedata_in[CTRL_TOOFF] ?
                       ST_DIS_DLL : ST_SRE;
        end
      end
      ST_DIS_DLL: begin
        // Disable the DLL before self refresh
        next_cmd   = mk_cmd(1'b1, OP_MRS, 3'h1, mr1_dis);
        set_off    = 1'b1;
        next_wait  = ld(MOD_CYC);
        next_ret   = ST_SRE;
        next_state = ST_WAIT;
      end
      ST_SRE: begin
        next_cmd   = mk_cmd(1'b0, OP_REF, 3'h0, 14'h0000);
        next_cke   = 1'b0;
        next_wait  = ld(CKSRE_CYC);
        next_ret   = ST_CLK_REQ;
        next_state = ST_WAIT;
      end
      ST_CLK_REQ: begin
        // Request only after the entry hold
        // any glitch of stability restarts the count
        next_req = 1'b1;
        if (!clk_stable_in || !clk_req) begin
          next_wait = ld(CKSRX_CYC);
        end else if (wait_done) begin
          next_state = ST_SRX;
        end else begin
          next_wait = wait_cnt - 1'b1;
        end
      end
      ST_SRX: begin
        // CKE stays high from here to the end
        next_cmd   = mk_cmd(1'b1, OP_NOP, 3'h0, 14'h0000);
        next_cke   = 1'b1;
        next_req   = 1'b0;
        next_wait  = ld(XS_CYC);
        next_ret   = to_off ? ST_MR2 : ST_EN_DLL;
        next_state = ST_WAIT;
      end
      ST_EN_DLL: begin
        next_cmd   = mk_cmd(1'b1, OP_MRS, 3'h1, mr1_en);
        clr_off    = 1'b1;
        next_wait  = ld(MRD_CYC);
        next_ret   = ST_RST_DLL;
        next_state = ST_WAIT;
      end
      ST_RST_DLL: begin
        next_cmd   = mk_cmd(1'b1, OP_MRS, 3'h0, mr0_rst);
        lock_load  = 1'b1;
        next_wait  = ld(MRD_CYC);
        next_ret   = ST_MR2;
        next_state = ST_WAIT;
      end
      ST_MR2: begin
        // Latency update for the new clock
        next_cmd   = mk_cmd(1'b1, OP_MRS, 3'h2, mr2_val);
        next_wait  = to_off ? ld(MRD_CYC) : ld(MOD_CYC);
        next_ret   = to_off ? ST_MR0 : ST_ZQ;
        next_state = ST_WAIT;
      end
      ST_MR0: begin
        // DLL-off latencies, DLL reset kept clear
        next_cmd   = mk_cmd(1'b1, OP_MRS, 3'h0, mr0_nrs);
        next_wait  = ld(MOD_CYC);
        next_ret   = ST_ZQ;
        next_state = ST_WAIT;
      end
      ST_ZQ: begin
        // Reached only after a full mode delay
        if (zq_en) begin
          next_cmd = mk_cmd(1'b1, OP_ZQ, 3'h0, zq_addr);
          zq_load  = 1'b1;
        end
        next_state = ST_FINISH;
      end
      ST_FINISH: begin
        if (lock_cnt == '0 && zq_cnt == '0 && !zq_load) begin
          finish     = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // One count per real clock edge
        if (wait_done) begin
          next_state = ret_state;
        end else begin
          next_wait = wait_cnt - 1'b1;
        end
      end
    endcase
  end

  // ****************************************
  // Registers of the sequencer
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state     <= ST_IDLE;
      ret_state <= ST_IDLE;
      wait_cnt  <= '0;
      cke_level <= 1'b1;
      clk_req   <= 1'b0;
      dram_out  <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1,
                     cas_n: 1'b1, we_n: 1'b1, odt: 1'b0,
                     ba: 3'h0, addr: 14'h0000};
    end else begin
      state     <= next_state;
      ret_state <= next_ret;
      wait_cnt  <= next_wait;
      cke_level <= next_cke;
      clk_req   <= next_req;
      dram_out  <= next_cmd;
    end
  end

  // Lock and calibration timers run beside the sequencer so that
  // the mode writes overlap the DLL lock time.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      lock_cnt <= '0;
      zq_cnt   <= '0;
    end else begin
      if (lock_load) begin
        lock_cnt <= ld(DLLK_CYC);
      end else if (lock_cnt != '0) begin
        lock_cnt <= lock_cnt - 1'b1;
      end
      if (zq_load) begin
        zq_cnt <= ld(ZQOPER_CYC);
      end else if (zq_cnt != '0) begin
        zq_cnt <= zq_cnt - 1'b1;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      dll_off <= 1'b0;
      done    <= 1'b0;
    end else begin
      // DLL mode as last written to the device
      if (set_off) begin
        dll_off <= 1'b1;
      end else if (clr_off) begin
        dll_off <= 1'b0;
      end
      // Done is sticky; a new start clears it
      if (finish) begin
        done <= 1'b1;
      end else if (go) begin
        done <= 1'b0;
      end
    end
  end

  assign clk_change_req_out = clk_req;

endmodule

/* File: tb/dll_switch_asserts.sv */
// Port checks for the DLL on/off switch sequencer.
// Assumes a bind onto dll_switch_ctrl, one clock, synchronous reset.
`timescale 1ns/100ps
module dll_switch_asserts
  import dll_switch_pkg::*;
(
  input wire logic      ref_clk_in,
  input wire logic      reset_n_in,
  input wire logic      clk_stable_in,
  input wire logic      clk_change_req_out,
  input wire dram_cmd_t dram_out
);
  // ****************************************
  // Command ages
  // ****************************************
  wire logic [3:0] cmd = {dram_out.cs_n, dram_out.ras_n, dram_out.cas_n, dram_out.we_n};
  wire logic       mrs = cmd == OP_MRS;
  wire logic       zq  = cmd == OP_ZQ;
  wire logic       ref_c = cmd == OP_REF;
  logic            cke_q;
  wire logic       srx = dram_out.cke && !cke_q;
  int              age_mrs, age_srx, age_sre, run_ok;

  function automatic int sat(input int a);
    return (a < 4095) ? a + 1 : a;
  endfunction

  // Ages saturate high after reset so a first command is never judged early
  always_ff @(posedge ref_clk_in) begin
    cke_q   <= !reset_n_in || dram_out.cke;
    age_mrs <= !reset_n_in ? 4095 : mrs ? 1 : sat(age_mrs);
    age_srx <= !reset_n_in ? 4095 : srx ? 1 : sat(age_srx);
    age_sre <= !reset_n_in ? 4095 : ref_c ? 1 : sat(age_sre);
    run_ok  <= (!reset_n_in || !clk_stable_in) ? 0 : sat(run_ok);
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking dc @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_odt_low: assert property (dram_out.odt == 1'h0)
    else $error("odt driven high");
  a_nop_fill: assert property (!(mrs || zq || ref_c) |-> cmd[3] || cmd == OP_NOP)
    else $error("unexpected command while waiting");
  a_cke_drop: assert property (!dram_out.cke && cke_q |-> ref_c)
    else $error("cke fell outside self refresh entry");
  a_req_after_sre: assert property ($rose(clk_change_req_out) |->
    !dram_out.cke && age_sre >= CKSRE_CYC)
    else $error("clock change too early");
  a_srx_stable: assert property (srx |-> run_ok >= CKSRX_CYC)
    else $error("self refresh exit on unstable clock");
  a_mrs_gap: assert property (mrs |-> age_mrs >= MRD_CYC)
    else $error("mode writes too close");
  a_sre_gap: assert property (ref_c |-> age_mrs >= MOD_CYC)
    else $error("self refresh too soon after mode write");
  a_xs_gap: assert property (mrs |-> age_srx >= XS_CYC)
    else $error("mode write too soon after exit");
  a_zq_gap: assert property (zq |-> age_mrs >= MOD_CYC && dram_out.addr[10])
    else $error("bad long calibration");

  c_srx: cover property (srx);
  c_zq: cover property (zq);
  c_req: cover property ($rose(clk_change_req_out));
endmodule

/* File: tb/dram_model.sv */
// DRAM side model: DLL state, mode write spacing, clock source.
// Assumes commands registered on the rising edge of clk_in.
`timescale 1ns/100ps
module dram_model
  import dll_switch_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire dram_cmd_t  cmd_in,
  input  wire logic       req_in,
  input  wire logic       slow_in,
  output logic            stable_out,
  output logic            dll_off_out,
  output logic [7:0]      viol_out
);
  wire logic is_mrs = {cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n} == OP_MRS;
  logic [7:0] gap;
  logic [7:0] settle;
  logic       req_q;

  // Clock drops out on request and settles after a short or long time
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      gap         <= 8'hFF;
      settle      <= 8'h00;
      req_q       <= 1'h0;
      stable_out  <= 1'h1;
      dll_off_out <= 1'h0;
      viol_out    <= 8'h00;
    end else begin
      req_q <= req_in;
      gap   <= is_mrs ? 8'h01 : (gap == 8'hFF) ? gap : gap + 8'h01;
      if (is_mrs && gap < MRD_CYC) viol_out <= viol_out + 8'h01;
      if (is_mrs && cmd_in.ba == 3'h1) dll_off_out <= cmd_in.addr[0];
      if (req_in && !req_q) begin
        stable_out <= 1'h0;
        settle     <= slow_in ? 8'h28 : 8'h02;
      end else if (settle != 8'h00) begin
        settle <= settle - 8'h01;
        if (settle == 8'h01) stable_out <= 1'h1;
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the DLL switch sequencer.
// Assumes the package offsets and the DRAM model beside the design.
`timescale 1ns/100ps
module testbench
  import dll_switch_pkg::*;
;
  logic ref_clk_in, reset_n_in, avs_read_in, avs_write_in, slow;
  logic [4:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic avs_waitrequest_out, clk_stable_in, clk_change_req_out, dll_off;
  logic [7:0] viol;
  dram_cmd_t dram_out;
  logic [16:0] mrs_q[$];
  int err_total, tests_run, cyc, lock_cyc, zq_cyc, zq_n, sre_n;

  dll_switch_ctrl i_dll_switch_ctrl (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .clk_stable_in(clk_stable_in), .clk_change_req_out(clk_change_req_out),
    .dram_out(dram_out));
  dram_model i_dram_model (.clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cmd_in(dram_out),
    .req_in(clk_change_req_out), .slow_in(slow), .stable_out(clk_stable_in),
    .dll_off_out(dll_off), .viol_out(viol));

  initial begin
    ref_clk_in = 1'h0;
    forever #12.5 ref_clk_in = !ref_clk_in;
  end

  // ****************************************
  // Command monitor and tasks
  // ****************************************
  wire logic [3:0] cmd = {dram_out.cs_n, dram_out.ras_n, dram_out.cas_n, dram_out.we_n};
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cmd == OP_MRS) mrs_q.push_back({dram_out.ba, dram_out.addr});
    if (cmd == OP_MRS && dram_out.ba == 3'h0 && dram_out.addr[8]) lock_cyc <= cyc;
    if (cmd == OP_ZQ) zq_cyc <= cyc;
    if (cmd == OP_ZQ) zq_n <= zq_n + 1;
    if (cmd == OP_REF && !dram_out.cke) sre_n <= sre_n + 1;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Request held until a rising edge sees waitrequest low; data taken at that edge
  task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge ref_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_read_in      <= !wr;
    avs_write_in     <= wr;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'h0 && n < 20);
    if (n >= 20) begin
      err_total++;
      close_out();
    end
    q = avs_readdata_out;
    avs_read_in  <= 1'h0;
    avs_write_in <= 1'h0;
  endtask

  task automatic wait_done(output int at);
    logic [31:0] s;
    int n;
    s = 32'h0000_0000;
    for (n = 0; n < 3000 && s[1] !== 1'h1; n++) avs(1'h0, STATUS_OFS, 32'h0000_0000, s);
    if (n >= 3000) begin
      err_total++;
      close_out();
    end
    at = cyc;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic regs_reset();
    logic [31:0] s;
    avs(1'h0, STATUS_OFS, 32'h0000_0000, s);
    check(s, 32'h0000_0000);
    avs(1'h0, MR0_OFS, 32'h0000_0000, s);
    check(s, 32'h0000_0000);
    avs(1'h1, MR2_OFS, 32'h0000_2A18, s);
    avs(1'h0, MR2_OFS, 32'h0000_0000, s);
    check(s, 32'h0000_2A18);
    avs(1'h1, 5'h14, 32'hFFFF_FFFF, s);
    avs(1'h0, 5'h14, 32'h0000_0000, s);
    check(s, 32'h0000_0000);
    avs(1'h1, STATUS_OFS, 32'h0000_00F7, s);
    avs(1'h0, STATUS_OFS, 32'h0000_0000, s);
    check(s, 32'h0000_0000);
  endtask

  task automatic off_run();
    logic [31:0] s;
    int t;
    mrs_q.delete();
    avs(1'h1, MR1_OFS, 32'h0000_0044, s);
    avs(1'h1, MR0_OFS, 32'h0000_0120, s);
    avs(1'h1, CTRL_OFS, 32'h0000_0007, s);
    wait_done(t);
    check(32'(mrs_q.size()), 32'h0000_0003);
    check(32'(mrs_q[0][16:14]), 32'h0000_0001);
    check(32'(mrs_q[0][0]), 32'h0000_0001);
    check(32'(mrs_q[1]), 32'h0000_AA18);
    check(32'(mrs_q[2]), 32'h0000_0020);
    check(32'(sre_n), 32'h0000_0001);
    check(32'(t - zq_cyc >= ZQOPER_CYC), 32'h0000_0001);
    avs(1'h0, STATUS_OFS, 32'h0000_0000, s);
    check(32'(s[2]), 32'h0000_0001);
    check(32'(dll_off), 32'h0000_0001);
  endtask

  // A second go while busy must not turn the switch around
  task automatic on_run();
    logic [31:0] s;
    int t;
    mrs_q.delete();
    slow <= 1'h1;
    avs(1'h1, CTRL_OFS, 32'h0000_0001, s);
    avs(1'h1, CTRL_OFS, 32'h0000_0003, s);
    wait_done(t);
    check(32'(mrs_q.size()), 32'h0000_0003);
    check(32'(mrs_q[0][16:14]), 32'h0000_0001);
    check(32'(mrs_q[0][0]), 32'h0000_0000);
    check(32'(mrs_q[1][16:14]), 32'h0000_0000);
    check(32'(mrs_q[1][8]), 32'h0000_0001);
    check(32'(mrs_q[2]), 32'h0000_AA18);
    check(32'(t - lock_cyc >= DLLK_CYC), 32'h0000_0001);
    check(32'(zq_n), 32'h0000_0001);
    check(32'(sre_n), 32'h0000_0002);
    check(32'(viol), 32'h0000_0000);
    avs(1'h0, STATUS_OFS, 32'h0000_0000, s);
    check(32'(s[2]), 32'h0000_0000);
    check(32'(dll_off), 32'h0000_0000);
  endtask

  initial begin
    reset_n_in       = 1'h0;
    avs_read_in      = 1'h0;
    avs_write_in     = 1'h0;
    avs_address_in   = 5'h00;
    avs_writedata_in = 32'h0000_0000;
    slow             = 1'h0;
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'h1;
    regs_reset();
    off_run();
    on_run();
    close_out();
  end
endmodule

bind dll_switch_ctrl dll_switch_asserts i_dll_switch_asserts (.ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in), .clk_stable_in(clk_stable_in),
  .clk_change_req_out(clk_change_req_out), .dram_out(dram_out));
